// ===== rtl/pch_pkg.sv
// package for the pin setup and high alarm qualifier register bank
// assumes a byte-wide register port already decoded from the serial host link
package pch_pkg;

   localparam logic [7:0] PIN_FUNCTION_SETUP_OFS         = 8'h12;
   localparam logic [7:0] HIGH_ALARM_QUALIFIER_SETUP_OFS = 8'h20;
   localparam logic [7:0] HIGH_THRESHOLD_MSB_OFS         = 8'h22;
   localparam logic [7:0] HIGH_THRESHOLD_LSB_OFS         = 8'h23;

   // pin_function_setup fields
   localparam int PIN_TRIGGER_ENABLE_BIT  = 7;
   localparam int TRIGGER_EDGE_SELECT_BIT = 6;
   localparam int IRQ_FUNCTION_LSB        = 2;
   localparam int IRQ_DRIVE_LSB           = 0;
   localparam logic [7:0] PIN_FUNCTION_SETUP_RST = 8'h04;
   localparam logic [7:0] PIN_FUNCTION_SETUP_MASK = 8'hCF;

   // high_alarm_qualifier_setup fields
   localparam int HIGH_EXCEED_COUNTER_LSB = 5;
   localparam int HIGH_TRIP_TYPE_BIT      = 3;
   localparam int HIGH_TRIP_COUNT_LSB     = 1;
   localparam int HIGH_COUNTER_CLEAR_BIT  = 0;
   localparam logic [7:0] HIGH_ALARM_QUALIFIER_SETUP_RST = 8'h00;

   localparam logic [15:0] HIGH_THRESHOLD_RST = 16'h7FFF;

   // irq drive codes
   localparam logic [1:0] IRQ_DRIVE_OPEN_DRAIN_LOW = 2'h0;
   localparam logic [1:0] IRQ_DRIVE_PUSH_HIGH      = 2'h1;
   localparam logic [1:0] IRQ_DRIVE_PUSH_LOW       = 2'h2;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pch_reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] temp;
   } pch_result_t;

endpackage

// ===== rtl/pch_high_qualifier.sv
// high alarm qualifier: exceedance counter, trip counting, alarm flag
// assumes one result pulse per finished conversion, same clock as caller
`timescale 1ns/10ps
`default_nettype none

module pch_high_qualifier (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire pch_pkg::pch_result_t result,
   input  wire logic [15:0]          high_threshold,
   input  wire logic                 high_trip_type,
   input  wire logic [1:0]           high_trip_count,
   input  wire logic                 high_counter_clear,
   input  wire logic                 alarm_flag_clear,
   output logic [2:0]                high_exceed_counter,
   output logic                      high_alarm_flag
);

   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic [2:0] run_r;
   logic [2:0] run_nxt;
   logic       flag_r;
   logic       flag_nxt;

   wire logic       exceed    = result.valid &&
                                ($signed(result.temp) > $signed(high_threshold));
   wire logic [2:0] need      = {1'b0, high_trip_count} + 3'h1;
   wire logic [2:0] cnt_inc   = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
   wire logic [2:0] run_inc   = (run_r == 3'h7) ? run_r : run_r + 3'h1;
   // consecutive mode needs an unbroken run; nonconsecutive uses the total
   wire logic [2:0] tally     = high_trip_type ? cnt_inc : run_inc;
   wire logic       trip      = exceed && (tally >= need);

   assign cnt_nxt  = high_counter_clear ? 3'h0 : (exceed ? cnt_inc : cnt_r);
   assign run_nxt  = high_counter_clear ? 3'h0 :
                     (result.valid ? (exceed ? run_inc : 3'h0) : run_r);
   // a trip in the clearing cycle wins over the clear
   assign flag_nxt = trip ? 1'b1 : (alarm_flag_clear ? 1'b0 : flag_r);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r  <= 3'h0;
         run_r  <= 3'h0;
         flag_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         run_r  <= run_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign high_exceed_counter = cnt_r;
   assign high_alarm_flag     = flag_r;

endmodule

`default_nettype wire

// ===== rtl/pch_pin_config_and_high_alarm.sv
// pin function setup, convert trigger handling and high alarm qualifier registers
// assumes a decoded byte register port from the serial host link on sys_clk;
// the shared pin is asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none

// Contract
// - pin off means power-down only, no converts
// - convert during conversion is dropped
// - edge bit selects active trigger edge
// - irq function field selects four behaviours
// - irq drive field selects pin driving
// - read-only saturating high exceedance count
// - trip type 0 needs consecutive exceedances
// - trip type 1 accepts nonconsecutive exceedances
// - no nonconsecutive trips in comparator mode
// - trip count code plus one exceedances
// - counter clear zeros count, self-clears
// - signed threshold, default 0x7FFF blocks alarm
module pch_pin_config_and_high_alarm #(
   parameter int SHORT_HOLD_CYC = 100,
   parameter int LONG_HOLD_CYC  = 1000
) (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire pch_pkg::pch_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   input  wire logic                  trigger_or_powerdown_pin,
   input  wire logic                  auto_mode_bit,
   input  wire logic                  one_shot_convert,
   input  wire logic                  comparator_mode,
   input  wire logic                  status_read,
   input  wire logic                  conversion_busy,
   input  wire pch_pkg::pch_result_t  result,
   output logic                       convert_start,
   output logic                       powerdown,
   output logic                       high_alarm_flag,
   output logic                       irq_out,
   output logic                       irq_oe
);

   typedef enum logic [1:0] {IRQ_OFF, IRQ_ON_READ, IRQ_SHORT, IRQ_LONG} pch_irq_fn_t;

   logic [7:0]  pin_setup_r;
   logic [3:0]  hq_setup_r;
   logic        clear_r;
   logic [15:0] thr_r;
   logic        pin_s1_r;
   logic        pin_s2_r;
   logic        pin_s3_r;
   logic        auto_r;
   logic        irq_r;
   logic        irq_nxt;
   logic [15:0] hold_r;
   logic [15:0] hold_nxt;
   logic [2:0]  high_exceed_counter;

   wire logic wr_pin  = reg_req.wr_en && (reg_req.addr == pch_pkg::PIN_FUNCTION_SETUP_OFS);
   wire logic wr_hq   = reg_req.wr_en &&
                        (reg_req.addr == pch_pkg::HIGH_ALARM_QUALIFIER_SETUP_OFS);
   wire logic wr_tmsb = reg_req.wr_en && (reg_req.addr == pch_pkg::HIGH_THRESHOLD_MSB_OFS);
   wire logic wr_tlsb = reg_req.wr_en && (reg_req.addr == pch_pkg::HIGH_THRESHOLD_LSB_OFS);

   wire logic        pin_en   = pin_setup_r[pch_pkg::PIN_TRIGGER_ENABLE_BIT];
   wire logic        edge_sel = pin_setup_r[pch_pkg::TRIGGER_EDGE_SELECT_BIT];
   wire pch_irq_fn_t irq_fn   = pch_irq_fn_t'(pin_setup_r[pch_pkg::IRQ_FUNCTION_LSB +: 2]);
   wire logic [1:0]  irq_drv  = pin_setup_r[pch_pkg::IRQ_DRIVE_LSB +: 2];
   // comparator mode forces consecutive counting
   wire logic        trip_type = hq_setup_r[3] && !comparator_mode;

   // edge select 0 picks the falling edge, 1 the rising one
   wire logic rise_det  = pin_s2_r && !pin_s3_r;
   wire logic fall_det  = !pin_s2_r && pin_s3_r;
   wire logic pin_edge  = edge_sel ? rise_det : fall_det;
   wire logic auto_kick = auto_mode_bit && !auto_r;
   wire logic reg_cmd   = one_shot_convert || auto_kick;
   wire logic cmd       = pin_en ? pin_edge : reg_cmd;
   // a busy converter drops the command instead of queueing it
   assign convert_start = cmd && !conversion_busy;
   assign powerdown     = !pin_en && !pin_s2_r;

   wire logic q_flag_clear = status_read;
   wire logic flag_rise;
   logic      flag_d_r;

   pch_high_qualifier u_qual (
      .sys_clk            (sys_clk),
      .srst               (srst),
      .result             (result),
      .high_threshold     (thr_r),
      .high_trip_type     (trip_type),
      .high_trip_count    (hq_setup_r[2:1]),
      .high_counter_clear (clear_r),
      .alarm_flag_clear   (q_flag_clear),
      .high_exceed_counter(high_exceed_counter),
      .high_alarm_flag    (high_alarm_flag)
   );

   assign flag_rise = high_alarm_flag && !flag_d_r;

   // irq level per function; self-clear modes time out by counter
   always_comb begin
      irq_nxt  = irq_r;
      hold_nxt = hold_r;
      case (irq_fn)
         IRQ_OFF: begin
            irq_nxt  = 1'b0;
            hold_nxt = 16'h0000;
         end
         IRQ_ON_READ: begin
            if (flag_rise)
               irq_nxt = 1'b1;
            else if (status_read)
               irq_nxt = 1'b0;
         end
         default: begin
            if (flag_rise) begin
               irq_nxt  = 1'b1;
               hold_nxt = (irq_fn == IRQ_SHORT) ? 16'(SHORT_HOLD_CYC) : 16'(LONG_HOLD_CYC);
            end else if (hold_r > 16'h0001) begin
               hold_nxt = hold_r - 16'h0001;
            end else begin
               irq_nxt  = 1'b0;
               hold_nxt = 16'h0000;
            end
         end
      endcase
   end

   // drive encodings; undefined code leaves the pin released
   always_comb begin
      irq_out = 1'b0;
      irq_oe  = 1'b0;
      if (irq_drv == pch_pkg::IRQ_DRIVE_OPEN_DRAIN_LOW) begin
         irq_out = 1'b0;
         irq_oe  = irq_r;
      end else if (irq_drv == pch_pkg::IRQ_DRIVE_PUSH_HIGH) begin
         irq_out = irq_r;
         irq_oe  = 1'b1;
      end else if (irq_drv == pch_pkg::IRQ_DRIVE_PUSH_LOW) begin
         irq_out = !irq_r;
         irq_oe  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_setup_r <= pch_pkg::PIN_FUNCTION_SETUP_RST;
         hq_setup_r  <= pch_pkg::HIGH_ALARM_QUALIFIER_SETUP_RST[3:0];
         clear_r     <= 1'b0;
         thr_r       <= pch_pkg::HIGH_THRESHOLD_RST;
      end else begin
         if (wr_pin)
            pin_setup_r <= reg_req.wdata & pch_pkg::PIN_FUNCTION_SETUP_MASK;
         if (wr_hq)
            hq_setup_r  <= {reg_req.wdata[3:1], 1'b0};
         clear_r <= wr_hq && reg_req.wdata[pch_pkg::HIGH_COUNTER_CLEAR_BIT];
         if (wr_tmsb)
            thr_r[15:8] <= reg_req.wdata;
         if (wr_tlsb)
            thr_r[7:0]  <= reg_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_s3_r <= 1'b1;
         auto_r   <= 1'b0;
         irq_r    <= 1'b0;
         hold_r   <= 16'h0000;
         flag_d_r <= 1'b0;
      end else begin
         pin_s1_r <= trigger_or_powerdown_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         auto_r   <= auto_mode_bit;
         irq_r    <= irq_nxt;
         hold_r   <= hold_nxt;
         flag_d_r <= high_alarm_flag;
      end
   end

   // read mux; clear bit and unused bits read zero
   wire logic [7:0] hq_view = {high_exceed_counter, 1'b0, hq_setup_r[3:1], 1'b0};
   always_ff @(posedge sys_clk) begin
      if (srst)
         reg_rdata <= 8'h00;
      else if (reg_req.rd_en && reg_req.addr == pch_pkg::PIN_FUNCTION_SETUP_OFS)
         reg_rdata <= pin_setup_r;
      else if (reg_req.rd_en && reg_req.addr == pch_pkg::HIGH_ALARM_QUALIFIER_SETUP_OFS)
         reg_rdata <= hq_view;
      else if (reg_req.rd_en && reg_req.addr == pch_pkg::HIGH_THRESHOLD_MSB_OFS)
         reg_rdata <= thr_r[15:8];
      else if (reg_req.rd_en && reg_req.addr == pch_pkg::HIGH_THRESHOLD_LSB_OFS)
         reg_rdata <= thr_r[7:0];
      else if (reg_req.rd_en)
         reg_rdata <= 8'h00;
   end

endmodule

`default_nettype wire

// ===== sim/pch_checker.sv
// checker: read port, convert gating and alarm flag relations at the top ports
// assumes it is bound onto the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module pch_checker #(
   parameter int SHORT_HOLD_CYC = 100,
   parameter int LONG_HOLD_CYC  = 1000
) (
   input wire logic                  sys_clk,
   input wire logic                  srst,
   input wire pch_pkg::pch_reg_req_t reg_req,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  trigger_or_powerdown_pin,
   input wire logic                  auto_mode_bit,
   input wire logic                  one_shot_convert,
   input wire logic                  comparator_mode,
   input wire logic                  status_read,
   input wire logic                  conversion_busy,
   input wire pch_pkg::pch_result_t  result,
   input wire logic                  convert_start,
   input wire logic                  powerdown,
   input wire logic                  high_alarm_flag,
   input wire logic                  irq_out,
   input wire logic                  irq_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_clr_rd;
      reg_req.wr_en && reg_req.addr == 8'h20 && reg_req.wdata[0]
         ##2 reg_req.rd_en && reg_req.addr == 8'h20;
   endsequence
   a_busy_drops_start: assert property (conversion_busy |-> !convert_start)
      else $error("start while busy");
   a_flag_has_cause: assert property ($rose(high_alarm_flag) |->
      $past(result.valid) || $past(result.valid, 2)) else $error("flag without result");
   a_flag_holds: assert property (high_alarm_flag && !status_read |=> high_alarm_flag)
      else $error("flag dropped");
   a_read_clears_flag: assert property (status_read && !result.valid
      && !$past(result.valid) |=> !high_alarm_flag) else $error("flag not cleared");
   a_reset_quiet: assert property ($fell(srst) |->
      reg_rdata == 8'h00 && !irq_oe && !high_alarm_flag) else $error("reset state");
   a_setup_gaps_zero: assert property (reg_req.rd_en && reg_req.addr == 8'h20
      |=> !reg_rdata[4] && !reg_rdata[0]) else $error("qualifier gap bits");
   a_pin_gaps_zero: assert property (reg_req.rd_en && reg_req.addr == 8'h12
      |=> reg_rdata[5:4] == 2'h0) else $error("pin setup gap bits");
   a_clear_counter: assert property (s_clr_rd |=> reg_rdata[7:5] == 3'h0)
      else $error("counter not cleared");
endmodule
bind pch_pin_config_and_high_alarm pch_checker #(.SHORT_HOLD_CYC(SHORT_HOLD_CYC),
   .LONG_HOLD_CYC(LONG_HOLD_CYC)) u_chk (.sys_clk(sys_clk), .srst(srst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .trigger_or_powerdown_pin(trigger_or_powerdown_pin),
   .auto_mode_bit(auto_mode_bit), .one_shot_convert(one_shot_convert),
   .comparator_mode(comparator_mode), .status_read(status_read),
   .conversion_busy(conversion_busy), .result(result), .convert_start(convert_start),
   .powerdown(powerdown), .high_alarm_flag(high_alarm_flag), .irq_out(irq_out),
   .irq_oe(irq_oe));
`default_nettype wire

// ===== sim/pch_conv_model.sv
// converter stand-in: busy for a fixed span per start, then one result pulse
// assumes starts come from the block under test on the same clock
`timescale 1ns/10ps
`default_nettype none
module pch_conv_model #(parameter int CONV_CYC = 4) (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic                 convert_start,
   input  wire logic [15:0]          temp_in,
   output var  logic                 conversion_busy,
   output var  pch_pkg::pch_result_t result
);
   int n = 0;
   initial conversion_busy = 1'b0;
   initial result = '0;
   always @(posedge sys_clk) begin
      // idle data is inverted so a stale sample never looks valid
      result <= {1'b0, ~temp_in};
      n <= n + 1;
      if (srst)
         conversion_busy <= 1'b0;
      else if (!conversion_busy && convert_start) begin
         conversion_busy <= 1'b1;
         n <= 1;
      end else if (conversion_busy && n == CONV_CYC) begin
         conversion_busy <= 1'b0;
         result <= {1'b1, temp_in};
      end
   end
endmodule
`default_nettype wire

// ===== sim/test_pch_pin_config_and_high_alarm.sv
// testbench: register readback, alarm qualification, trigger pin handling
// assumes the converter model answers each accepted start
`timescale 1ns/10ps
`default_nettype none
module test_pch_pin_config_and_high_alarm;
   logic                  sys_clk = 1'b0;
   logic                  srst = 1'b1;
   pch_pkg::pch_reg_req_t reg_req = '0;
   logic                  pin = 1'b1;
   logic                  one_shot = 1'b0;
   logic                  auto_m = 1'b0;
   logic                  status_read = 1'b0;
   logic [15:0]           temp_in = 16'h0000;
   logic [7:0]            reg_rdata, r, exp_q[$];
   logic                  busy, cvt, pd, flag, irq_out, irq_oe, rd_d = 1'b0;
   pch_pkg::pch_result_t  result;
   int                    n_fail = 0, total_checks = 0, n_start = 0, n0;
   always #5 sys_clk = ~sys_clk;
   pch_pin_config_and_high_alarm #(.SHORT_HOLD_CYC(4), .LONG_HOLD_CYC(8)) dut (
      .sys_clk(sys_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .trigger_or_powerdown_pin(pin), .auto_mode_bit(auto_m), .one_shot_convert(one_shot),
      .comparator_mode(1'b0), // kept off, trip type 1 is used
      .status_read(status_read), .conversion_busy(busy), .result(result),
      .convert_start(cvt), .powerdown(pd), .high_alarm_flag(flag), .irq_out(irq_out),
      .irq_oe(irq_oe));
   pch_conv_model #(.CONV_CYC(4)) u_conv (.sys_clk(sys_clk), .srst(srst),
      .convert_start(cvt), .temp_in(temp_in), .conversion_busy(busy), .result(result));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (n_fail == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      reg_req <= {w, !w, a, d};
      tick(1);
      reg_req <= '0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic conv(input logic [15:0] t);
      status_read <= 1'b0;
      temp_in <= t;
      one_shot <= 1'b1;
      tick(1);
      one_shot <= 1'b0;
      tick(2);
      one_shot <= 1'b1; // lands while busy
      tick(1);
      one_shot <= 1'b0;
      tick(8);
   endtask
   task automatic pin_to(input logic v);
      pin <= v;
      tick(6);
   endtask
   // read data stands from the cycle after the request
   always @(posedge sys_clk) begin
      if (rd_d)
         chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_req.rd_en;
      if (cvt)
         n_start++;
   end
   initial begin
      tick(20000);
      n_fail++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h6E9D2551));
      tick(20);
      srst <= 1'b0;
      tick(1);
      rd(8'h12, 8'h04);
      rd(8'h20, 8'h00);
      rd(8'h22, 8'h7F);
      rd(8'h23, 8'hFF);
      rd(8'h30, 8'h00);
      for (int i = 0; i < 3; i++) begin
         r = 8'($urandom);
         bus(1'b1, 8'h12, r);
         rd(8'h12, r & 8'hCF);
      end
      bus(1'b1, 8'h20, 8'hFF);
      rd(8'h20, 8'h0E);
      bus(1'b1, 8'h12, 8'h04);
      bus(1'b1, 8'h20, 8'h00);
      conv(16'h7FFF);
      chk(flag, 8'h00);
      bus(1'b1, 8'h22, 8'h01);
      bus(1'b1, 8'h23, 8'h00);
      for (int c = 0; c < 4; c++) begin
         status_read <= 1'b1;
         tick(1);
         conv(16'h0100); // equal to threshold, not an exceedance
         bus(1'b1, 8'h20, {5'h00, 2'(c), 1'b1});
         repeat (c) conv(16'h0101);
         chk(flag, 8'h00);
         conv(16'h0100);
         repeat (c) conv(16'h0101);
         chk(flag, 8'h00);
         conv(16'h0101);
         chk(flag, 8'h01);
         chk({irq_oe, irq_out}, 8'h02);
         rd(8'h20, {(c == 3) ? 3'h7 : 3'(2 * c + 1), 2'h0, 2'(c), 1'b0});
      end
      // one more exceedance past seven must stick at seven
      conv(16'h0101);
      rd(8'h20, 8'hE6);
      status_read <= 1'b1;
      tick(1);
      conv(16'h0100);
      bus(1'b1, 8'h20, 8'h0B);
      conv(16'h0101);
      chk(flag, 8'h00);
      conv(16'h0100);
      conv(16'h0101);
      chk(flag, 8'h01);
      bus(1'b1, 8'h20, 8'h0B);
      rd(8'h20, 8'h0A);
      // long self-clear with push-pull active high, then push-pull active low idle
      bus(1'b1, 8'h12, 8'h0D);
      status_read <= 1'b1;
      bus(1'b1, 8'h20, 8'h01);
      conv(16'h0101);
      chk({irq_oe, irq_out}, 8'h03);
      tick(8);
      chk({irq_oe, irq_out}, 8'h02);
      bus(1'b1, 8'h12, 8'h0E);
      chk({irq_oe, irq_out}, 8'h03);
      for (int e = 1; e >= 0; e--) begin
         bus(1'b1, 8'h12, {1'b1, 1'(e), 6'h04});
         n0 = n_start;
         pin_to(!1'(e));
         pin_to(1'(e));
         pin_to(!1'(e));
         chk(8'(n_start - n0), 8'h01);
      end
      n0 = n_start;
      conv(16'h0100);
      auto_m <= 1'b1;
      tick(4);
      auto_m <= 1'b0;
      chk(8'(n_start - n0), 8'h00);
      bus(1'b1, 8'h12, 8'h04);
      pin_to(1'b0);
      chk(pd, 8'h01);
      pin_to(1'b1);
      chk(8'(n_start - n0), 8'h00);
      // with the pin off, a register kick starts a conversion again
      auto_m <= 1'b1;
      tick(4);
      chk(8'(n_start - n0), 8'h01);
      report_and_stop();
   end
endmodule
`default_nettype wire
